// ---- rtl/rtas_scaler.sv ----
`timescale 1ns/1ns
`include "rtas_cfg.svh"
module rtas_scaler (
	// clock and reset
	input  wire logic                       clk,
	input  wire logic                       rst_n,
	// measurement
	input  wire logic                       readingStrobe,
	input  wire logic [`RTAS_RES_W-1:0]     readingKohm,
	input  wire logic                       overRange,
	input  wire logic                       testActive,
	// settings
	input  wire rtas_pkg::rtas_span_e       spanMode,
	input  wire rtas_pkg::rtas_range_e      resRange,
	input  wire logic [10:0]                testVolts,
	// outputs
	output logic [`RTAS_DAC_W-1:0]          dacCode,
	output logic                            dacUpdate,
	output logic                            underRange
);
	import rtas_pkg::*;

	logic rstMeta;
	logic rstSyncN;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rstMeta  <= 1'b0;
			rstSyncN <= 1'b0;
		end else begin
			rstMeta  <= 1'b1;
			rstSyncN <= rstMeta;
		end
	end

	function automatic logic [`RTAS_RES_W-1:0] rangeSpan(input rtas_range_e r);
		unique case (r)
			RTAS_RNG_2M:    rangeSpan = `RTAS_SPAN_4M;
			RTAS_RNG_20M:   rangeSpan = `RTAS_SPAN_40M;
			RTAS_RNG_200M:  rangeSpan = `RTAS_SPAN_400M;
			default:        rangeSpan = `RTAS_SPAN_4000M;
		endcase
	endfunction : rangeSpan

	function automatic logic [`RTAS_RES_W-1:0] underLimit(input rtas_range_e r);
		unique case (r)
			RTAS_RNG_2M:    underLimit = '0;
			RTAS_RNG_20M:   underLimit = `RTAS_UNDER_20R;
			RTAS_RNG_200M:  underLimit = `RTAS_UNDER_200R;
			default:        underLimit = `RTAS_UNDER_2000R;
		endcase
	endfunction : underLimit

	// span chosen by mode
	logic [`RTAS_RES_W-1:0] span;
	always_comb begin
		if (spanMode == RTAS_SPAN_FULL) begin
			// band only, range ignored
			span = (testVolts < `RTAS_VBAND_HI) ? `RTAS_SPAN_400M
				: `RTAS_SPAN_4000M;
		end else begin
			span = rangeSpan(resRange);
		end
	end

	logic isUnder;
	assign isUnder = (readingKohm < underLimit(resRange));

	// latch the forcing flags with the reading so the divider result pairs with them
	logic overQ;
	logic underQ;
	logic pendQ;
	logic divStart;
	logic divDone;
	logic [`RTAS_DAC_W-1:0] divQuot;

	// only readings during a test refresh; otherwise level holds
	assign divStart = readingStrobe && testActive;

	always_ff @(posedge clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			overQ  <= 1'b0;
			underQ <= 1'b0;
			pendQ  <= 1'b0;
		end else if (divStart) begin
			overQ  <= overRange;
			underQ <= isUnder && !overRange;
			pendQ  <= 1'b1;
		end else if (divDone) begin
			pendQ  <= 1'b0;
		end
	end

	rtas_scale_div #(
		.RW (`RTAS_RES_W),
		.DW (`RTAS_DAC_W)
	) uDiv (
		.clk      (clk),
		.rstSyncN (rstSyncN),
		.start    (divStart),
		.num      (readingKohm),
		.den      (span),
		.done     (divDone),
		.quot     (divQuot)
	);

	// linear from 0 at zero reading to full code at the selected span
	always_ff @(posedge clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			dacCode    <= `RTAS_DAC_ZERO;
			dacUpdate  <= 1'b0;
			underRange <= 1'b0;
		end else begin
			dacUpdate <= 1'b0;
			if (divDone && pendQ) begin
				dacUpdate  <= 1'b1;
				underRange <= underQ;
				if (overQ) begin
					dacCode <= `RTAS_DAC_FULL;
				end else if (underQ) begin
					dacCode <= `RTAS_DAC_ZERO;
				end else begin
					dacCode <= divQuot;
				end
			end
		end
	end
endmodule : rtas_scaler

// ---- rtl/rtas_cfg.svh ----
`ifndef RTAS_CFG_SVH
`define RTAS_CFG_SVH

// readings arrive in kilohm units (0.001 megohm resolution)
`define RTAS_RES_W        23
`define RTAS_DAC_W        16
`define RTAS_DAC_FULL     16'hffff
`define RTAS_DAC_ZERO     16'h0000
// full-scale spans in kilohm
`define RTAS_SPAN_4M      23'h000fa0
`define RTAS_SPAN_40M     23'h009c40
`define RTAS_SPAN_400M    23'h061a80
`define RTAS_SPAN_4000M   23'h3d0900
// under-range thresholds in kilohm
`define RTAS_UNDER_20R    23'h00076c
`define RTAS_UNDER_200R   23'h004a38
`define RTAS_UNDER_2000R  23'h02e630
// test voltage boundary in volts
`define RTAS_VBAND_HI     11'h064
`endif

// ---- rtl/rtas_pkg.sv ----
package rtas_pkg;
	typedef enum logic {
		RTAS_SPAN_FULL,
		RTAS_SPAN_EACH
	} rtas_span_e;
	typedef enum logic [2:0] {
		RTAS_RNG_2M,
		RTAS_RNG_20M,
		RTAS_RNG_200M,
		RTAS_RNG_2000M,
		RTAS_RNG_4000M
	} rtas_range_e;
endpackage : rtas_pkg

// ---- rtl/rtas_scale_div.sv ----
`timescale 1ns/1ns
// sequential restoring divide: quot = num * 2^DW / den, saturated to all ones
module rtas_scale_div #(
	parameter int RW = 23,
	parameter int DW = 16
) (
	// clock and reset
	input  wire logic          clk,
	input  wire logic          rstSyncN,
	// request
	input  wire logic          start,
	input  wire logic [RW-1:0] num,
	input  wire logic [RW-1:0] den,
	// answer
	output logic               done,
	output logic      [DW-1:0] quot
);
	localparam int CW = $clog2(DW + 1);
	// quotient shift needs at least two bits on each side
	if (RW < 2 || DW < 2) begin : gWidthCheck
		$error("rtas_scale_div: widths too small");
	end

	logic [RW:0]   remQ;
	logic [RW-1:0] denQ;
	logic [DW-1:0] accQ;
	logic [CW-1:0] cntQ;
	logic          busyQ;
	logic          satQ;
	logic [RW+1:0] trial;

	assign trial = {remQ, 1'b0} - {2'b00, denQ};

	always_ff @(posedge clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			remQ  <= '0;
			denQ  <= '0;
			accQ  <= '0;
			cntQ  <= '0;
			busyQ <= 1'b0;
			satQ  <= 1'b0;
			done  <= 1'b0;
			quot  <= '0;
		end else begin
			done <= 1'b0;
			if (start) begin
				// reading at or above span saturates; avoids a wide quotient
				satQ  <= (num >= den);
				remQ  <= {1'b0, num};
				denQ  <= den;
				accQ  <= '0;
				cntQ  <= CW'(DW);
				busyQ <= 1'b1;
			end else if (busyQ) begin
				if (!trial[RW+1]) begin
					remQ <= trial[RW:0];
					accQ <= {accQ[DW-2:0], 1'b1};
				end else begin
					remQ <= {remQ[RW-1:0], 1'b0};
					accQ <= {accQ[DW-2:0], 1'b0};
				end
				cntQ <= cntQ - 1'b1;
				if (cntQ == CW'(1)) begin
					busyQ <= 1'b0;
					done  <= 1'b1;
					quot  <= satQ ? '1 :
						(trial[RW+1] ? {accQ[DW-2:0], 1'b0} : {accQ[DW-2:0], 1'b1});
				end
			end
		end
	end
endmodule : rtas_scale_div

// ---- verif/rtas_scaler_monitor.sv ----
`timescale 1ns/1ns
`include "rtas_cfg.svh"
module rtas_scaler_monitor import rtas_pkg::*; (
	input logic clk, rst_n, readingStrobe, overRange, testActive, dacUpdate, underRange,
	input logic [22:0] readingKohm,
	input rtas_span_e spanMode,
	input rtas_range_e resRange,
	input logic [10:0] testVolts,
	input logic [15:0] dacCode
);
	logic take, ov_q;
	logic [22:0] rk_q;
	assign take = readingStrobe & testActive;
	// strobes come 18+ apart, so the snapshot still holds at the answer
	always_ff @(posedge clk) if (take) begin
		ov_q <= overRange;
		rk_q <= readingKohm;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	a_update_lat: assert property (take |-> ##18 dacUpdate) else $error("late");
	a_update_src: assert property (dacUpdate |-> $past(take, 18)) else $error("stray");
	a_update_pulse: assert property (dacUpdate |=> !dacUpdate) else $error("long");
	a_level_hold: assert property (!dacUpdate |-> $stable({dacCode, underRange}))
		else $error("moved");
	a_over_full: assert property (dacUpdate && ov_q |-> dacCode == `RTAS_DAC_FULL)
		else $error("over");
	a_over_wins: assert property (dacUpdate && ov_q |-> !underRange) else $error("both");
	a_under_zero: assert property (underRange |-> dacCode == `RTAS_DAC_ZERO)
		else $error("under");
	a_span_top: assert property (dacUpdate && rk_q >= `RTAS_SPAN_4000M
		|-> dacCode == `RTAS_DAC_FULL) else $error("top");
	c_over: cover property (dacUpdate && ov_q);
	c_under: cover property (dacUpdate && underRange);
	c_fresh: cover property (dacUpdate && !ov_q && !underRange);
endmodule : rtas_scaler_monitor
bind rtas_scaler rtas_scaler_monitor mon_u (.*);

// ---- verif/rtas_recorder_model.sv ----
`timescale 1ns/1ns
// recorder input: takes a new level only when one is announced
module rtas_recorder_model (
	input logic clk, dacUpdate, underRange,
	input logic [15:0] dacCode,
	output logic got,
	output logic [16:0] level
);
	always_ff @(posedge clk) begin
		got <= dacUpdate;
		if (dacUpdate) level <= {underRange, dacCode};
	end
endmodule : rtas_recorder_model

// ---- verif/rtas_scaler_bench.sv ----
`timescale 1ns/1ns
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin err_count++; \
	$display("ERROR %s exp %h got %h", n, e, g); end end
module rtas_scaler_bench;
	import rtas_pkg::*;
	logic clk = 0, rst_n = 0, stb = 0, ovr = 0, act = 0, upd, und, got;
	logic [22:0] k = '0;
	logic [10:0] tv = 11'h64;
	logic [15:0] code;
	logic [16:0] lvl, want, q[$];
	rtas_span_e sm = RTAS_SPAN_FULL;
	rtas_range_e rg = RTAS_RNG_2M;
	int err_count = 0, n_checks = 0, cyc = 0;
	rtas_scaler dut_u (.clk(clk), .rst_n(rst_n), .readingStrobe(stb), .readingKohm(k),
		.overRange(ovr), .testActive(act), .spanMode(sm), .resRange(rg), .testVolts(tv),
		.dacCode(code), .dacUpdate(upd), .underRange(und));
	rtas_recorder_model rec_u (.clk(clk), .dacUpdate(upd), .dacCode(code), .underRange(und),
		.got(got), .level(lvl));
	function automatic logic [16:0] expect_lvl();
		logic [22:0] sp;
		logic each;
		each = sm == RTAS_SPAN_EACH;
		sp = (each ? rg == RTAS_RNG_200M : tv < 11'h64) ? 23'h61a80 : 23'h3d0900;
		if (each && rg == RTAS_RNG_2M) sp = 23'hfa0;
		if (each && rg == RTAS_RNG_20M) sp = 23'h9c40;
		if (ovr) return 17'h0ffff;
		if (rg == RTAS_RNG_20M && k < 23'h76c || rg == RTAS_RNG_200M && k < 23'h4a38
			|| rg > RTAS_RNG_200M && k < 23'h2e630) return 17'h10000;
		return k >= sp ? 17'h0ffff : {1'b0, 16'({k, 16'h0} / sp)};
	endfunction : expect_lvl
	initial forever #2 clk = ~clk;
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			err_count++;
			test_done();
		end
		if (got) begin
			// an update with nothing noted can never match
			want = q.size() ? q.pop_front() : 17'h1ffff;
			`CHK("level", want, lvl)
		end
	end
	task automatic test_done();
		$display("checks %0d errors %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : test_done
	initial begin
		void'($urandom(32'hd686));
		repeat (16) @(posedge clk);
		#1 rst_n = 1;
		repeat (80) begin
			repeat (21) @(posedge clk);
			#1 stb = 1;
			act = $urandom % 8 != 0;
			ovr = $urandom % 8 == 0;
			sm = rtas_span_e'($urandom % 2);
			rg = rtas_range_e'($urandom % 5);
			tv = $urandom % 2 ? 11'h63 : 11'h64;
			k = 23'($urandom) >> ($urandom % 26);
			if (act) q.push_back(expect_lvl());
			@(posedge clk);
			#1 stb = 0;
		end
		repeat (25) @(posedge clk);
		`CHK("pending", 0, q.size())
		test_done();
	end
endmodule : rtas_scaler_bench
